// [rtl/ebau_top.sv]
// byte storage access unit: 512-byte store behind io registers
// assumes the processor drives io_req on ref_clk and honours cpu_stall
// Contract
// - 512-byte store, byte access, linear addresses 0 to 511.
// - address, data and control registers sit in io register space.
// - nine-bit address over high and low registers; bits 15..9 read zero.
// - a write programs the data register byte at the addressed location.
// - a read loads the addressed byte into the data register.
// - a read trigger stalls the processor four cycles.
// - a write trigger stalls the processor two cycles.
// - writes are self-timed and completion is visible to software.
// - writes start only through the protected arm-then-strobe sequence.
// - strobe must follow arm within four cycles; arm self-clears after four.
// - write strobe reads set while programming, cleared by hardware after.
// - read is immediate; during a write, reads and address changes ignored.
// - mode 00 erase+write, 01 erase, 10 write only, 11 reserved.
`timescale 1ns/100ps
module ebau_top
  import ebau_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_DIV_CYC,
  parameter logic [11:0] ATOMIC_TICKS = ATOMIC_TICKS_DEF,
  parameter logic [11:0] SPLIT_TICKS = SPLIT_TICKS_DEF
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire ebau_io_req_t io_req,
  output logic [7:0] io_rdata,
  output logic cpu_stall,
  output logic write_busy
);

  logic [7:0] store_mem [STORE_BYTES];
  logic [8:0] addr_r;
  logic [7:0] data_r;
  logic [1:0] mode_r;
  logic rdyie_r;
  logic arm_r;
  logic [2:0] arm_cnt_r;
  logic [2:0] stall_r;
  logic [7:0] rdata_r;
  logic [8:0] op_addr_r;
  logic [7:0] op_data_r;
  ebau_mode_t op_mode_r;
  logic busy;
  logic done;
  logic ctrl_wr;
  logic read_go;
  logic write_go;
  logic [1:0] wr_mode;
  logic [7:0] rd_mux;

  function automatic logic io_hit(input logic [5:0] a, input logic [5:0] o);
    return a == o;
  endfunction

  function automatic logic [11:0] prog_ticks(input ebau_mode_t m);
    return (m == MODE_ATOMIC) ? ATOMIC_TICKS : SPLIT_TICKS;
  endfunction

  assign ctrl_wr = io_req.wr && io_hit(io_req.addr, OFS_CTRL);
  assign wr_mode = io_req.wdata[CTRL_MODE_LO +: 2];
  // read fires at once unless a write is running
  assign read_go = ctrl_wr && io_req.wdata[CTRL_READ_BIT] && !busy;
  // strobe only counts while armed; reserved mode starts nothing
  assign write_go = ctrl_wr && io_req.wdata[CTRL_WRITE_BIT] && arm_r
    && !busy && (wr_mode != 2'(MODE_RSVD));

  ebau_timer #(
    .TICK_DIV(TICK_DIV)
  ) u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(write_go),
    .ticks(prog_ticks(ebau_mode_t'(wr_mode))),
    .busy(busy),
    .done(done)
  );

  assign write_busy = busy;
  assign cpu_stall = (stall_r != 3'h0);
  assign io_rdata = rdata_r;

  // address: frozen while programming
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= ADDR_RST;
    end else if (io_req.wr && !busy) begin
      if (io_hit(io_req.addr, OFS_ADDR_LO)) begin
        addr_r[7:0] <= io_req.wdata;
      end else if (io_hit(io_req.addr, OFS_ADDR_HI)) begin
        addr_r[8] <= io_req.wdata[0];
      end
    end
  end

  // data register: software write or read result
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_r <= DATA_RST;
    end else if (read_go) begin
      data_r <= store_mem[addr_r];
    end else if (io_req.wr && io_hit(io_req.addr, OFS_DATA)) begin
      data_r <= io_req.wdata;
    end
  end

  // mode and ready-enable bits; mode locked while busy
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= MODE_RST;
      rdyie_r <= 1'b0;
    end else if (ctrl_wr) begin
      rdyie_r <= io_req.wdata[CTRL_RDYIE_BIT];
      if (!busy) begin
        mode_r <= wr_mode;
      end
    end
  end

  // arm bit: set by software, cleared four cycles later
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      arm_r <= 1'b0;
      arm_cnt_r <= 3'h0;
    end else if (ctrl_wr && io_req.wdata[CTRL_ARM_BIT] && !arm_r) begin
      arm_r <= 1'b1;
      arm_cnt_r <= ARM_WINDOW_CYC - 3'h1;
    end else if (arm_r) begin
      if (arm_cnt_r == 3'h0) begin
        arm_r <= 1'b0;
      end else begin
        arm_cnt_r <= arm_cnt_r - 3'h1;
      end
    end
  end

  // processor stall after read or write trigger
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stall_r <= 3'h0;
    end else if (read_go) begin
      stall_r <= READ_STALL_CYC;
    end else if (write_go) begin
      stall_r <= WRITE_STALL_CYC;
    end else if (stall_r != 3'h0) begin
      stall_r <= stall_r - 3'h1;
    end
  end

  // operation latched at start so later register writes cannot corrupt it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_addr_r <= ADDR_RST;
      op_data_r <= DATA_RST;
      op_mode_r <= MODE_ATOMIC;
    end else if (write_go) begin
      op_addr_r <= addr_r;
      op_data_r <= data_r;
      op_mode_r <= ebau_mode_t'(wr_mode);
    end
  end

  // store array, committed when the write time expires
  always_ff @(posedge ref_clk) begin
    if (done) begin
      unique case (op_mode_r)
        MODE_ATOMIC: store_mem[op_addr_r] <= op_data_r;
        MODE_ERASE: store_mem[op_addr_r] <= ERASED_BYTE;
        MODE_WRITE: store_mem[op_addr_r] <= store_mem[op_addr_r] & op_data_r;
        MODE_RSVD: store_mem[op_addr_r] <= store_mem[op_addr_r];
      endcase
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (io_req.addr)
      OFS_CTRL: rd_mux = {2'b00, mode_r, rdyie_r, arm_r, busy, 1'b0};
      OFS_DATA: rd_mux = data_r;
      OFS_ADDR_LO: rd_mux = addr_r[7:0];
      OFS_ADDR_HI: rd_mux = {7'h00, addr_r[8]};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else if (io_req.rd) begin
      rdata_r <= rd_mux;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_addr_hi_zero: assert property (
    io_req.rd && io_hit(io_req.addr, OFS_ADDR_HI) |=> rdata_r[7:1] == 7'h00)
    else $error("address high upper bits not zero");
  a_arm_four_cyc: assert property (
    $rose(arm_r) |-> arm_r [*4] ##1 !arm_r)
    else $error("arm bit did not clear after four cycles");
  a_read_stall: assert property (
    read_go |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  a_write_stall: assert property (
    write_go |=> cpu_stall [*2] ##1 !cpu_stall)
    else $error("write stall not two cycles");
  a_strobe_busy: assert property (
    io_req.rd && io_hit(io_req.addr, OFS_CTRL)
      |=> rdata_r[CTRL_WRITE_BIT] == $past(busy))
    else $error("write strobe readback differs from busy");
  a_unarmed_ignored: assert property (
    ctrl_wr && io_req.wdata[CTRL_WRITE_BIT] && !arm_r && !busy |=> !busy)
    else $error("write started without arm");
  a_read_loads: assert property (
    read_go |=> data_r == $past(store_mem[addr_r]))
    else $error("read did not load addressed byte");
  a_addr_locked: assert property (
    busy && io_req.wr |=> addr_r == $past(addr_r))
    else $error("address changed during write");
  a_mode_locked: assert property (
    busy && ctrl_wr |=> mode_r == $past(mode_r))
    else $error("mode changed during write");
  a_atomic_commit: assert property (
    done && op_mode_r == MODE_ATOMIC |=> store_mem[$past(op_addr_r)]
      == $past(op_data_r))
    else $error("atomic write did not store data byte");

endmodule

// [include/ebau_pkg.sv]
// constants and types shared by the storage access unit and its write timer
// assumes a single 50 MHz clock and a processor io register port
package ebau_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned STORE_BYTES = 512;
  localparam int unsigned ADDR_W = 9;

  // io register offsets
  localparam logic [5:0] OFS_CTRL = 6'h1F;
  localparam logic [5:0] OFS_DATA = 6'h20;
  localparam logic [5:0] OFS_ADDR_LO = 6'h21;
  localparam logic [5:0] OFS_ADDR_HI = 6'h22;

  // control register field positions
  localparam int unsigned CTRL_READ_BIT = 0;
  localparam int unsigned CTRL_WRITE_BIT = 1;
  localparam int unsigned CTRL_ARM_BIT = 2;
  localparam int unsigned CTRL_RDYIE_BIT = 3;
  localparam int unsigned CTRL_MODE_LO = 4;

  // values after reset, and the erased byte value
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [8:0] ADDR_RST = 9'h000;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // cycle counts
  localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;
  localparam logic [2:0] READ_STALL_CYC = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYC = 3'h2;

  // write durations, timed in 1 us ticks of a divided clock
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_DIV_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned PROG_ATOMIC_US = 3400;
  localparam int unsigned PROG_SPLIT_US = 1800;
  localparam logic [11:0] ATOMIC_TICKS_DEF =
    12'(PROG_ATOMIC_US * 1000 / TICK_NS);
  localparam logic [11:0] SPLIT_TICKS_DEF =
    12'(PROG_SPLIT_US * 1000 / TICK_NS);

  typedef enum logic [1:0] {
    MODE_ATOMIC,
    MODE_ERASE,
    MODE_WRITE,
    MODE_RSVD
  } ebau_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } ebau_io_req_t;

endpackage

// [rtl/ebau_timer.sv]
// self-timed write duration counter with its own tick divider
// assumes start only arrives while idle
`timescale 1ns/100ps
module ebau_timer
  import ebau_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_DIV_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [11:0] ticks,
  output logic busy,
  output logic done
);

  logic [15:0] div_r;
  logic [11:0] left_r;
  logic busy_r;
  logic tick;

  // divided enable stands in for the slow timing oscillator
  assign tick = busy_r && (div_r == 16'(TICK_DIV - 1));
  assign done = tick && (left_r == 12'h001);
  assign busy = busy_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 16'h0000;
    end else if (start || tick) begin
      div_r <= 16'h0000;
    end else if (busy_r) begin
      div_r <= div_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      left_r <= 12'h000;
    end else if (start) begin
      busy_r <= 1'b1;
      left_r <= ticks;
    end else if (tick) begin
      left_r <= left_r - 12'h001;
      if (left_r == 12'h001) begin
        busy_r <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_done_ends_busy: assert property (done |=> !busy)
    else $error("timer busy did not drop after done");
  a_busy_only_done: assert property ($fell(busy_r) |-> $past(done))
    else $error("timer busy dropped without done");

endmodule

// [verif/ebau_cpu_model.sv]
// processor side model: issues one io register access at a time
// assumes ref_clk from the bench; drives on the falling edge
`timescale 1ns/100ps
module ebau_cpu_model
  import ebau_pkg::*;
(
  input wire logic ref_clk,
  input wire logic cpu_stall,
  output ebau_io_req_t io_req
);
  logic stuck = 1'b0;

  initial io_req = '0;

  task automatic op(input logic w, input logic r, input logic [5:0] a,
                    input logic [7:0] d);
    int k;
    @(negedge ref_clk);
    // no new access while the core is held
    for (k = 0; k < 20 && cpu_stall !== 1'b0; k++) begin
      @(negedge ref_clk);
    end
    // core held too long: the bench counts it and ends the run
    if (cpu_stall !== 1'b0) stuck = 1'b1;
    io_req = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge ref_clk);
    io_req = '0;
  endtask
endmodule

// [verif/eeprom_byte_access_unit_tb.sv]
// self-checking bench for the byte storage access unit
// assumes shortened write timing set through the top parameters
`timescale 1ns/100ps
module eeprom_byte_access_unit_tb
  import ebau_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  ebau_io_req_t io_req;
  logic [7:0] io_rdata;
  logic cpu_stall;
  logic write_busy;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] d, e;
  logic [8:0] a;
  int bad_count = 0;
  int checks = 0;

  always #10 ref_clk = ~ref_clk;

  ebau_top #(.TICK_DIV(2), .ATOMIC_TICKS(12'h008), .SPLIT_TICKS(12'h003))
  dut (.ref_clk(ref_clk), .reset_n(reset_n), .io_req(io_req),
       .io_rdata(io_rdata), .cpu_stall(cpu_stall),
       .write_busy(write_busy));

  ebau_cpu_model cpu (.ref_clk(ref_clk), .cpu_stall(cpu_stall),
                      .io_req(io_req));

  task automatic chk_rdata(input logic [7:0] x, input logic [7:0] g);
    checks++;
    if (g !== x) begin
      bad_count++;
      $display("BAD io_rdata expected %h seen %h", x, g);
    end
  endtask

  task automatic chk_stall(input logic [7:0] x, input logic [7:0] g);
    checks++;
    if (g !== x) begin
      bad_count++;
      $display("BAD cpu_stall cycles expected %0d seen %0d", x, g);
    end
  endtask

  task automatic chk_busy(input logic x, input logic g);
    checks++;
    if (g !== x) begin
      bad_count++;
      $display("BAD write_busy expected %b seen %b", x, g);
    end
  endtask

  task automatic summarize();
    // a read that never answered is a mismatch too
    if (exp_q.size() != 0) bad_count++;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // read data is due one cycle after the read request
  always @(posedge ref_clk) rd_d <= io_req.rd;
  always @(negedge ref_clk) begin
    if (rd_d === 1'b1 && exp_q.size() > 0) begin
      chk_rdata(exp_q.pop_front(), io_rdata);
    end
  end

  // processor model gave up waiting on the stall
  always @(posedge cpu.stuck) begin
    bad_count++;
    summarize();
  end

  task automatic cnt(input logic [7:0] es, input logic eb);
    logic [7:0] n;
    logic b;
    n = 8'h00;
    b = 1'b0;
    repeat (6) begin
      n = n + {7'h00, cpu_stall};
      b = b | write_busy;
      @(negedge ref_clk);
    end
    chk_stall(es, n);
    chk_busy(eb, b);
  endtask

  task automatic wt();
    int k;
    for (k = 0; k < 100 && write_busy !== 1'b0; k++) @(negedge ref_clk);
    if (write_busy !== 1'b0) begin
      bad_count++;
      summarize();
    end
  endtask

  task automatic set_a(input logic [8:0] x);
    cpu.op(1'b1, 1'b0, OFS_ADDR_HI, {7'h00, x[8]});
    cpu.op(1'b1, 1'b0, OFS_ADDR_LO, x[7:0]);
  endtask

  // arm first, then strobe with the same mode
  task automatic wr(input logic [7:0] x, input logic [1:0] m,
                    input logic [7:0] es, input logic eb);
    cpu.op(1'b1, 1'b0, OFS_DATA, x);
    cpu.op(1'b1, 1'b0, OFS_CTRL, {2'h0, m, 4'h4});
    cpu.op(1'b1, 1'b0, OFS_CTRL, {2'h0, m, 4'h6});
    cnt(es, eb);
  endtask

  task automatic rdreg(input logic [5:0] o, input logic [7:0] x);
    exp_q.push_back(x);
    cpu.op(1'b0, 1'b1, o, 8'h00);
  endtask

  task automatic rd(input logic [7:0] x);
    cpu.op(1'b1, 1'b0, OFS_CTRL, 8'h01);
    cnt(8'h04, 1'b0);
    rdreg(OFS_DATA, x);
  endtask

  initial begin
    void'($urandom(42));
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    rdreg(OFS_DATA, DATA_RST);
    cpu.op(1'b1, 1'b0, OFS_ADDR_HI, 8'hFF);
    rdreg(OFS_ADDR_HI, 8'h01);
    rdreg(6'h05, 8'h00);
    set_a(9'h1FF);
    d = 8'($urandom());
    e = 8'($urandom());
    wr(d, 2'h0, 8'h02, 1'b1);
    wt();
    rd(d);
    wr(8'h00, 2'h1, 8'h02, 1'b1);
    wt();
    rd(8'hFF);
    wr(d, 2'h0, 8'h02, 1'b1);
    wt();
    wr(e, 2'h2, 8'h02, 1'b1);
    wt();
    rd(d & e);
    wr(8'h00, 2'h3, 8'h00, 1'b0);
    rd(d & e);
    a = 9'($urandom());
    set_a(a);
    wr(e, 2'h0, 8'h02, 1'b1);
    rdreg(OFS_CTRL, 8'h02);
    cpu.op(1'b1, 1'b0, OFS_ADDR_LO, ~a[7:0]);
    // read strobe and mode 11 while busy: both must be ignored
    cpu.op(1'b1, 1'b0, OFS_CTRL, 8'h31);
    rdreg(OFS_CTRL, 8'h02);
    rdreg(OFS_DATA, e);
    wt();
    rd(e);
    cpu.op(1'b1, 1'b0, OFS_CTRL, 8'h02);
    cnt(8'h00, 1'b0);
    cpu.op(1'b1, 1'b0, OFS_CTRL, 8'h04);
    repeat (5) @(negedge ref_clk);
    cpu.op(1'b1, 1'b0, OFS_CTRL, 8'h06);
    cnt(8'h00, 1'b0);
    summarize();
  end
endmodule
